//--- core/rlem_pkg.sv
// rlem_pkg: register map, field positions and widths of the remote line error monitor.
// assumes byte-wide registers, each placed in one aligned 32-bit APB word (byte address = 4*index).
package rlem_pkg;
  localparam int RLEM_ADDR_W = 16;
  localparam int RLEM_DATA_W = 32;
  localparam int RLEM_REG_W = 8;
  localparam int RLEM_TALLY_W = 32;
  // register indices; the byte address is four times the index
  localparam logic [13:0] RLEM_IDX_CONTROL_0 = 14'h1103;
  localparam logic [13:0] RLEM_IDX_IRQ_STATUS_0 = 14'h110B;
  localparam logic [13:0] RLEM_IDX_IRQ_MASK_0 = 14'h1120;
  localparam logic [13:0] RLEM_IDX_TALLY_3 = 14'h1118;
  localparam logic [13:0] RLEM_IDX_TALLY_2 = 14'h1119;
  localparam logic [13:0] RLEM_IDX_TALLY_1 = 14'h111A;
  localparam logic [13:0] RLEM_IDX_TALLY_0 = 14'h111B;
  // control byte fields
  localparam int RLEM_CTRL_COUNT_MODE_BIT = 2;
  localparam int RLEM_CTRL_FRAMING_STD_BIT = 3;
  localparam logic [7:0] RLEM_CTRL_WRITABLE = 8'h7F;
  localparam logic [7:0] RLEM_CTRL_RESET = 8'h00;
  // interrupt status fields
  localparam int RLEM_STAT_REMOTE_ERR_BIT = 5;
  localparam logic [7:0] RLEM_STAT_IMPLEMENTED = 8'h20;
  localparam logic [7:0] RLEM_STAT_RESET = 8'h00;
  localparam logic [7:0] RLEM_MASK_RESET = 8'h00;
  localparam logic [31:0] RLEM_TALLY_RESET = 32'h0000_0000;
  // largest value the far end normally reports per frame
  localparam logic [7:0] RLEM_REMOTE_ERR_TYPICAL_MAX = 8'h18;
  // apb slave states
  typedef enum logic [1:0] {
    RLEM_ST_IDLE = 2'b01,
    RLEM_ST_ANSWER = 2'b10
  } rlem_apb_state_t;
endpackage

//--- core/rlem_frame_if.sv
// rlem_frame_if: per-frame remote error event passed from the extractor to the register core.
// assumes both ends run on the same clock; evt is a one-cycle pulse.
`timescale 1ns/10ps
interface rlem_frame_if;
  logic evt;
  logic [7:0] value;
  modport src (output evt, output value);
  modport dst (input evt, input value);
endinterface

//--- core/rlem_frame_rx.sv
// rlem_frame_rx: takes the error-report byte of each received frame and flags non-zero values.
// assumes frame_strobe is a one-cycle pulse from framing logic on the same clock.
`timescale 1ns/10ps
module rlem_frame_rx
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // per-frame overhead byte
  input wire logic frame_strobe,
  input wire logic [7:0] line_error_report_byte,
  // event towards the register core
  rlem_frame_if.src evt_out
);
  import rlem_pkg::*;

  logic evt;
  logic [7:0] value;
  logic next_evt;

  // whole byte carries the value; zero means an error-free frame
  assign next_evt = frame_strobe && (line_error_report_byte != 8'h00);

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      evt <= 1'b0;
      value <= 8'h00;
    end
    else
    begin
      evt <= next_evt;
      if (frame_strobe)
      begin
        value <= line_error_report_byte;
      end
    end
  end

  assign evt_out.evt = evt;
  assign evt_out.value = value;
endmodule

//--- core/rlem_top.sv
// rlem_top: receive-side remote line error monitor with its APB register file.
// assumes the frame strobe and overhead byte come from framing logic on the same clock.
//
// What this block does
// - every received frame's error-report byte is examined and its remote error value taken out.
// - a frame with a non-zero value sets status bit 5 at 0x110B and drives the low interrupt.
// - each frame with a non-zero value increases the remote error tally by the mode's step.
// - the tally is a 32-bit counter that software reads as four bytes.
// - tally bits 31:24 sit at 0x1118 and the following bytes run down to bits 7:0 at 0x111B.
// - with count mode bit 2 of the control byte at 0 the reported value is added to the tally.
// - with count mode bit 2 at 1 exactly one is added per frame with a non-zero value.
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
module rlem_top
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rlem_pkg::RLEM_ADDR_W-1:0] paddr,
  input wire logic [rlem_pkg::RLEM_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [rlem_pkg::RLEM_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // received frame overhead
  input wire logic frame_strobe,
  input wire logic [7:0] line_error_report_byte,
  // interrupt, active low
  output logic irq_n
);
  import rlem_pkg::*;

  rlem_frame_if frame_evt ();

  rlem_frame_rx u_frame_rx
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .frame_strobe(frame_strobe),
    .line_error_report_byte(line_error_report_byte),
    .evt_out(frame_evt)
  );

  // apb handshake state
  rlem_apb_state_t state;
  rlem_apb_state_t next_state;

  // register contents
  logic [7:0] rx_line_control_0;
  logic [7:0] rx_line_irq_status_0;
  logic [7:0] rx_line_irq_mask_0;
  logic [RLEM_TALLY_W-1:0] remote_error_tally;

  // address decode
  logic [13:0] reg_index;
  logic word_aligned;
  logic hit_control;
  logic hit_status;
  logic hit_mask;
  logic [3:0] hit_tally;
  logic hit_any;

  // phase qualifiers
  logic setup_seen;
  logic answer_edge;
  logic read_take;
  logic write_take;
  logic low_lane_written;

  // next values
  logic [7:0] next_control;
  logic [7:0] next_status;
  logic [7:0] next_mask;
  logic [RLEM_TALLY_W-1:0] next_tally;
  logic [RLEM_TALLY_W-1:0] tally_after_clear;
  logic [RLEM_TALLY_W-1:0] tally_step;
  logic [RLEM_TALLY_W-1:0] tally_clear_mask;
  logic [7:0] status_set;
  logic [7:0] status_clear;
  logic [7:0] read_byte;
  logic [RLEM_DATA_W-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq_n;
  logic count_mode;

  // per-register access strobes
  logic read_status;
  logic write_control;
  logic write_mask;
  logic [3:0] read_tally;
  logic [7:0] irq_bit;

  assign reg_index = paddr[15:2];
  assign word_aligned = (paddr[1:0] == 2'b00);

  assign hit_control = word_aligned && (reg_index == RLEM_IDX_CONTROL_0);
  assign hit_status = word_aligned && (reg_index == RLEM_IDX_IRQ_STATUS_0);
  assign hit_mask = word_aligned && (reg_index == RLEM_IDX_IRQ_MASK_0);

  // byte 3 is the most significant, at the lowest index
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_tally_dec
      localparam logic [13:0] IDX = RLEM_IDX_TALLY_0 - 14'(gi);
      assign hit_tally[gi] = word_aligned && (reg_index == IDX);
      assign read_tally[gi] = read_take && hit_tally[gi];
      assign tally_clear_mask[gi*8 +: 8] = read_tally[gi] ? 8'h00 : 8'hFF;
    end
  endgenerate

  assign hit_any = hit_control || hit_status || hit_mask || (hit_tally != 4'b0000);

  // one wait state: the answer is prepared in the first access cycle
  assign setup_seen = psel && penable && (state == RLEM_ST_IDLE);
  assign answer_edge = psel && penable && (state == RLEM_ST_ANSWER);
  // read side effects happen once, when the data is captured
  assign read_take = setup_seen && !pwrite && hit_any;
  assign write_take = answer_edge && pwrite && hit_any;
  assign low_lane_written = pstrb[0];
  assign read_status = read_take && hit_status;
  assign write_control = write_take && hit_control && low_lane_written;
  assign write_mask = write_take && hit_mask && low_lane_written;

  // apb state machine
  always_comb
  begin
    next_state = state;
    case (state)
      RLEM_ST_IDLE:
      begin
        if (psel && penable)
        begin
          next_state = RLEM_ST_ANSWER;
        end
      end
      RLEM_ST_ANSWER:
      begin
        next_state = RLEM_ST_IDLE;
      end
      default:
      begin
        next_state = RLEM_ST_IDLE;
      end
    endcase
  end

  assign next_pready = (next_state == RLEM_ST_ANSWER);
  assign next_pslverr = setup_seen && !hit_any;

  // read mux: narrow registers sit in the low byte, upper bits read as zero
  assign read_byte = hit_control ? rx_line_control_0 :
                     hit_status ? rx_line_irq_status_0 :
                     hit_mask ? rx_line_irq_mask_0 :
                     hit_tally[3] ? remote_error_tally[31:24] :
                     hit_tally[2] ? remote_error_tally[23:16] :
                     hit_tally[1] ? remote_error_tally[15:8] :
                     hit_tally[0] ? remote_error_tally[7:0] :
                     8'h00;

  assign next_prdata = read_take ? {24'h000000, read_byte} : 32'h0000_0000;

  // control byte; bit 7 stays zero
  assign next_control = write_control ?
                        (pwdata[7:0] & RLEM_CTRL_WRITABLE) : rx_line_control_0;
  assign next_mask = write_mask ?
                     (pwdata[7:0] & RLEM_STAT_IMPLEMENTED) : rx_line_irq_mask_0;

  assign count_mode = rx_line_control_0[RLEM_CTRL_COUNT_MODE_BIT];

  // sticky status per flag: a new event in the read cycle survives the clear
  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++)
    begin : g_status_bit
      assign status_set[gb] = frame_evt.evt && (gb == RLEM_STAT_REMOTE_ERR_BIT);
      assign status_clear[gb] = read_status;
      assign next_status[gb] = RLEM_STAT_IMPLEMENTED[gb] &&
                               ((rx_line_irq_status_0[gb] && !status_clear[gb]) ||
                                status_set[gb]);
      assign irq_bit[gb] = next_status[gb] && next_mask[gb];
    end
  endgenerate

  // step per errored frame; the value is taken whole, values above 24 are not trimmed
  assign tally_step = !frame_evt.evt ? RLEM_TALLY_RESET :
                      count_mode ? 32'h0000_0001 :
                      {24'h000000, frame_evt.value};

  // cleared byte first, then the step, so a same-cycle count is not lost
  assign tally_after_clear = remote_error_tally & tally_clear_mask;
  assign next_tally = tally_after_clear + tally_step;

  // released once no enabled flag remains
  assign next_irq_n = ~|irq_bit;

  // apb handshake
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= RLEM_ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= next_pready;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= next_pslverr;
    end
  end

  // read data only in the answer cycle, zero otherwise
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata <= 32'h0000_0000;
    end
    else
    begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_line_control_0 <= RLEM_CTRL_RESET;
    end
    else
    begin
      rx_line_control_0 <= next_control;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_line_irq_mask_0 <= RLEM_MASK_RESET;
    end
    else
    begin
      rx_line_irq_mask_0 <= next_mask;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_line_irq_status_0 <= RLEM_STAT_RESET;
    end
    else
    begin
      rx_line_irq_status_0 <= next_status;
    end
  end

  // wraps silently at 2^32; software is expected to poll well before
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      remote_error_tally <= RLEM_TALLY_RESET;
    end
    else
    begin
      remote_error_tally <= next_tally;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_n <= 1'b1;
    end
    else
    begin
      irq_n <= next_irq_n;
    end
  end
endmodule

//--- sim/rlem_far_end.sv
// rlem_far_end: far-end line equipment model, one report byte per frame.
// assumes the bench calls send from a single process.
`timescale 1ns/10ps
module rlem_far_end
(
  // clock
  input wire logic clock,
  // frame overhead
  output logic frame_strobe,
  output logic [7:0] line_error_report_byte
);
  initial
  begin
    frame_strobe = 1'b0;
    line_error_report_byte = 8'h00;
  end
  // zero when clean, else the error count seen; byte inverted between frames
  task automatic send(input logic [7:0] value);
    @(posedge clock);
    frame_strobe <= 1'b1;
    line_error_report_byte <= value;
    @(posedge clock);
    frame_strobe <= 1'b0;
    line_error_report_byte <= ~value;
  endtask
endmodule

//--- sim/rlem_top_assertions.sv
// rlem_top_assertions: port checks for the remote error monitor.
// assumes the mask stays put while the interrupt is pending.
`timescale 1ns/10ps
module rlem_chk
  import rlem_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // frame and interrupt
  input wire logic frame_strobe,
  input wire logic [7:0] line_error_report_byte,
  input wire logic irq_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire ev = frame_strobe && line_error_report_byte != 8'h00;
  wire [13:0] idx = paddr[15:2];
  wire tally = idx >= RLEM_IDX_TALLY_3 && idx <= RLEM_IDX_TALLY_0;
  wire mapped = paddr[1:0] == 2'b00 && (tally || idx == RLEM_IDX_CONTROL_0
    || idx == RLEM_IDX_IRQ_STATUS_0 || idx == RLEM_IDX_IRQ_MASK_0);
  wire stat_acc = psel && idx == RLEM_IDX_IRQ_STATUS_0;
  wire mask_wr = psel && penable && pready && pwrite && pstrb[0] && mapped
    && idx == RLEM_IDX_IRQ_MASK_0;
  logic mask_on;
  logic [2:0] ev_hist;
  // mask shadow; only bit 5 matters
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mask_on <= 1'b0;
      ev_hist <= 3'b000;
    end
    else
    begin
      ev_hist <= {ev_hist[1:0], ev};
      if (mask_wr)
        mask_on <= pwdata[RLEM_STAT_REMOTE_ERR_BIT];
    end
  end
  sequence s_status_read;
    psel && penable && !pready && !pwrite && idx == RLEM_IDX_IRQ_STATUS_0;
  endsequence
  sequence s_error_frame;
    mask_on && ev;
  endsequence
  chk_irq_raise: assert property (s_error_frame |-> ##[2:3] !irq_n)
    else $error("irq not raised");
  chk_irq_hold: assert property (!irq_n && mask_on && !stat_acc && !mask_wr |=> !irq_n)
    else $error("irq dropped early");
  // events just before the read would set the flag again, so leave them out
  chk_irq_release: assert property (s_status_read ##0 (ev_hist == 3'b000 && !ev)
    |-> ##[1:3] irq_n)
    else $error("irq not released");
  chk_irq_masked: assert property (!mask_on && !$past(mask_on) |-> irq_n)
    else $error("masked irq asserted");
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready held");
  chk_err_decode: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong");
  chk_read_width: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
endmodule
bind rlem_top rlem_chk u_rlem_chk (.clock(clock), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_strobe(frame_strobe),
  .line_error_report_byte(line_error_report_byte), .irq_n(irq_n));

//--- sim/rlem_top_tb.sv
// rlem_top_tb: self-checking bench for the remote error monitor.
// assumes the far-end model and the bound checker.
`timescale 1ns/10ps
module rlem_top_tb;
  import rlem_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic frame_strobe;
  logic [7:0] line_error_report_byte;
  logic irq_n;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #50 clock = ~clock;
  rlem_top u_rlem_top (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_strobe(frame_strobe),
    .line_error_report_byte(line_error_report_byte), .irq_n(irq_n));
  rlem_far_end u_rlem_far_end (.clock(clock), .frame_strobe(frame_strobe),
    .line_error_report_byte(line_error_report_byte));
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // request held until pready is seen high at a rising edge; data taken at that edge
  task automatic bus_raw(input logic wr, input logic [15:0] addr, input logic [31:0] wd,
    input logic [3:0] strb);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    pstrb <= strb;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // upper data bits set on purpose: the block must ignore them
  task automatic bus(input logic wr, input logic [13:0] idx, input logic [7:0] wd);
    bus_raw(wr, {idx, 2'b00}, {24'hFFFFFF, wd}, wr ? 4'hF : 4'h0);
  endtask
  task automatic rd_chk(input logic [13:0] idx, input logic [7:0] exp, input string what);
    bus(1'b0, idx, 8'h00);
    check(what, rd, {24'h000000, exp});
  endtask
  task automatic tally_chk(input logic [31:0] exp);
    for (int i = 0; i < 4; i++)
      rd_chk(RLEM_IDX_TALLY_3 + 14'(i), exp[31 - 8 * i -: 8], "tally byte");
  endtask
  task automatic t_control();
    rd_chk(RLEM_IDX_CONTROL_0, RLEM_CTRL_RESET, "control reset");
    bus(1'b1, RLEM_IDX_CONTROL_0, 8'hFF);
    rd_chk(RLEM_IDX_CONTROL_0, 8'h7F, "control bit7");
    bus(1'b1, RLEM_IDX_CONTROL_0, 8'h00);
    bus_raw(1'b1, {RLEM_IDX_CONTROL_0, 2'b00}, 32'h0000_0004, 4'hE);
    rd_chk(RLEM_IDX_CONTROL_0, RLEM_CTRL_RESET, "control lane off");
    bus_raw(1'b0, {RLEM_IDX_CONTROL_0, 2'b01}, 32'h0000_0000, 4'h0);
    check("misaligned err", {31'h0, err}, 32'h1);
    check("misaligned data", rd, 32'h0000_0000);
    bus(1'b0, 14'h1104, 8'h00);
    check("unmapped", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0000_0000);
    tally_chk(RLEM_TALLY_RESET);
  endtask
  task automatic t_value_mode();
    bus(1'b1, RLEM_IDX_IRQ_MASK_0, 8'h20);
    u_rlem_far_end.send(8'h05);
    u_rlem_far_end.send(8'h00);
    u_rlem_far_end.send(8'h18);
    repeat (4) @(negedge clock);
    check("irq low", {31'h0, irq_n}, 32'h0);
    rd_chk(RLEM_IDX_IRQ_STATUS_0, 8'h20, "status set");
    rd_chk(RLEM_IDX_IRQ_STATUS_0, 8'h00, "status clear");
    check("irq high", {31'h0, irq_n}, 32'h1);
    tally_chk(32'h0000_001D);
    tally_chk(32'h0000_0000);
  endtask
  // values above the usual range still count once
  task automatic t_frame_mode();
    bus(1'b1, RLEM_IDX_CONTROL_0, 8'h04);
    u_rlem_far_end.send(8'h01);
    u_rlem_far_end.send(8'h00);
    u_rlem_far_end.send(8'hC8);
    u_rlem_far_end.send(8'h18);
    tally_chk(32'h0000_0003);
    rd_chk(RLEM_IDX_IRQ_STATUS_0, 8'h20, "status mode1");
  endtask
  task automatic t_carry();
    bus(1'b1, RLEM_IDX_CONTROL_0, 8'h00);
    bus(1'b1, RLEM_IDX_IRQ_MASK_0, 8'h00);
    repeat (11) u_rlem_far_end.send(8'h18);
    repeat (4) @(negedge clock);
    check("irq masked", {31'h0, irq_n}, 32'h1);
    tally_chk(32'h0000_0108);
    rd_chk(RLEM_IDX_IRQ_STATUS_0, 8'h20, "status masked");
  endtask
  initial
  begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    t_control();
    t_value_mode();
    t_frame_mode();
    t_carry();
    test_done();
  end
  // a hung handshake ends the run as a failure
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      test_done();
    end
  end
endmodule
